// ==== acq_gate_pkg.sv ====
/*
  Shared constants for the acquisition start trigger gate: the register
  map, the field positions, the reset values and the gate states.
  Assumes a 32-bit AHB-Lite register bus with one aligned word a register.
*/
package acq_gate_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] FRAMES_OFFSET = 8'h04;
  localparam logic [7:0] CMD_OFFSET    = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam int         ADDR_BITS     = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields.
  localparam int CTRL_GATING_BIT   = 0;  // Acquisition start gating on.
  localparam int CTRL_TARGET_BIT   = 1;  // 1 = acquisition start selected.
  localparam int CTRL_ORIGIN_BIT   = 2;  // 1 = external line, 0 = software.
  localparam int CTRL_POLARITY_BIT = 3;  // 1 = falling edge, 0 = rising.
  localparam int CTRL_RUNMODE_BIT  = 4;  // 1 = continuous, 0 = single.
  localparam int CTRL_WIDTH        = 5;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h10;

  // Command register bits; writing a one fires the command once.
  localparam int CMD_BEGIN_BIT   = 0;
  localparam int CMD_END_BIT     = 1;
  localparam int CMD_TRIGGER_BIT = 2;

  // Status register fields.
  localparam int STATUS_STATE_LSB = 0;  // Two bits of gate state.
  localparam int STATUS_COUNT_LSB = 8;  // Frame starts taken so far.

  ////////////////////////////////////////////////////////////////////////////
  // Frames per acquisition range and reset value.
  localparam int         COUNT_WIDTH  = 8;
  localparam logic [7:0] FRAMES_MIN   = 8'h01;
  localparam logic [7:0] FRAMES_MAX   = 8'hFF;
  localparam logic [7:0] FRAMES_RESET = 8'h01;

  // AHB transfer type and response codes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Gate states as shown in the status register.
  typedef enum logic [1:0] {
    GATE_IDLE,
    GATE_WAIT_ACQ,
    GATE_WAIT_FRAME
  } gate_state_e;

endpackage

// ==== line_edge_detect.sv ====
/*
  Synchroniser and edge detector for external input line 1.
  Assumes the line is asynchronous to ref_clk; edges shorter than two
  clock periods may be missed.
*/
module line_edge_detect (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic lineIn,
  output logic      risePulse,
  output logic      fallPulse
);

  logic syncFirst_reg;
  logic syncSecond_reg;
  logic lineLast_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops tame metastability; only the second one feeds the compare.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncFirst_reg  <= 1'b0;
      syncSecond_reg <= 1'b0;
      lineLast_reg   <= 1'b0;
    end else begin
      syncFirst_reg  <= lineIn;
      syncSecond_reg <= syncFirst_reg;
      lineLast_reg   <= syncSecond_reg;
    end
  end

  // Edge pulses last one clock each.
  assign risePulse = syncSecond_reg & ~lineLast_reg;
  assign fallPulse = ~syncSecond_reg & lineLast_reg;

endmodule // line_edge_detect

// ==== acq_start_gate.sv ====
/*
  Acquisition start trigger gate with an AHB-Lite register slave.
  Assumes frameStartIn is a one-clock pulse from logic on ref_clk and that
  line 1 arrives asynchronously on a pin.
*/
// Notes on behaviour
// R01: Frames per acquisition accepts 1 to 255; other writes are ignored.
// R02: Host programs frames per acquisition before relying on the gate.
// R03: With gating on, capture begins in waiting for acquisition start.
// R04: Waiting for acquisition start ignores frame starts; no exposure begins.
// R05: An acquisition start trigger moves the gate to waiting for frame start.
// R06: After the programmed number of frame starts, return to waiting.
// R07: Every later acquisition start trigger reopens the gate again.
// R08: Host selects acquisition start target before issuing host trigger.
// R09: Host trigger with acquisition target and software origin is a trigger.
// R10: With line origin, acquisition start comes from line 1 edges.
// R11: Polarity select picks rising or falling edge; the other is ignored.
// R12: Host keeps continuous run mode while gating is on.
// R13: With gating off, acquisition start is made internally at once.
// R14: Host issues capture begin before frame starts can be accepted.
// R15: Each frame start while waiting for it starts one frame; the code starts none when capture end comes in the same cycle.
// R16: Frame counter clears on entry and counts only accepted frame starts.
// R17: Capture end returns the gate to idle and clears the counter.
module acq_start_gate
  import acq_gate_pkg::*;
(
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic                           hsel,
  input  wire logic [acq_gate_pkg::ADDR_BITS-1:0] haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  input  wire logic                           lineIn,
  input  wire logic                           frameStartIn,
  output logic [31:0]                         hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  output logic                                frameBegin,
  output logic                                waitingAcqStart,
  output logic                                waitingFrameStart
);
  import acq_gate_pkg::*;

  logic [CTRL_WIDTH-1:0]  ctrl_reg;
  logic [COUNT_WIDTH-1:0] frames_reg;
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [COUNT_WIDTH-1:0] count_next;
  gate_state_e            state_reg;
  gate_state_e            state_next;
  logic                   wrPending_reg;
  logic [ADDR_BITS-1:0]   wrAddr_reg;
  logic [31:0]            hrdata_reg;
  logic                   hreadyout_reg;
  logic                   frameBegin_reg;
  logic                   waitAcq_reg;
  logic                   waitFrame_reg;

  logic                   risePulse;
  logic                   fallPulse;
  logic                   addrPhase;
  logic                   wrCtrl;
  logic                   wrFrames;
  logic                   wrCmd;
  logic                   cmdBegin;
  logic                   cmdEnd;
  logic                   cmdTrigger;
  logic                   gatingOn;
  logic                   softAcqTrig;
  logic                   lineAcqTrig;
  logic                   acqTrig;
  logic                   frameTaken;
  logic                   lastFrame;
  logic                   framesValid;
  logic [31:0]            readData;

  // Compares a register address with a map offset.
  function automatic logic hit(input logic [ADDR_BITS-1:0] a,
                               input logic [ADDR_BITS-1:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line 1 synchronised, with one-clock edge pulses.
  line_edge_detect lineEdge (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .lineIn    (lineIn),
    .risePulse (risePulse),
    .fallPulse (fallPulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. Writes land in the data phase, one clock after address.
  assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign wrCtrl    = wrPending_reg & hit(wrAddr_reg, CTRL_OFFSET);
  assign wrFrames  = wrPending_reg & hit(wrAddr_reg, FRAMES_OFFSET);
  assign wrCmd     = wrPending_reg & hit(wrAddr_reg, CMD_OFFSET);
  assign cmdBegin   = wrCmd & hwdata[CMD_BEGIN_BIT];
  assign cmdEnd     = wrCmd & hwdata[CMD_END_BIT];
  assign cmdTrigger = wrCmd & hwdata[CMD_TRIGGER_BIT];
  assign framesValid = (hwdata[COUNT_WIDTH-1:0] >= FRAMES_MIN) &&
                       (hwdata[COUNT_WIDTH-1:0] <= FRAMES_MAX)  &&
                       (hwdata[31:COUNT_WIDTH] == '0); // see R01

  // Read mux; unmapped addresses and the command register read zero.
  assign readData =
    hit(haddr, CTRL_OFFSET)   ? {{(32-CTRL_WIDTH){1'b0}}, ctrl_reg} :
    hit(haddr, FRAMES_OFFSET) ? {{(32-COUNT_WIDTH){1'b0}}, frames_reg} :
    hit(haddr, STATUS_OFFSET) ? {16'h0000, count_reg, 6'h00, state_reg} :
                                32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger sources.
  assign gatingOn    = ctrl_reg[CTRL_GATING_BIT];
  assign softAcqTrig = cmdTrigger & ctrl_reg[CTRL_TARGET_BIT] &
                       ~ctrl_reg[CTRL_ORIGIN_BIT];      // see R09
  assign lineAcqTrig = ctrl_reg[CTRL_ORIGIN_BIT] &     // see R10
                       (ctrl_reg[CTRL_POLARITY_BIT] ? fallPulse
                                                    : risePulse); // see R11
  assign acqTrig     = softAcqTrig | lineAcqTrig;

  // A frame start only counts while the gate waits for it.
  assign frameTaken = (state_reg == GATE_WAIT_FRAME) & frameStartIn; // see R04
  assign lastFrame  = gatingOn & (count_reg + 8'h01 == frames_reg); // see R06

  ////////////////////////////////////////////////////////////////////////////
  // Gate sequencing. Capture end wins over every other event.
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    if (cmdEnd) begin
      state_next = GATE_IDLE;                           // see R17
      count_next = '0;                                  // see R17
    end else begin
      case (state_reg)
        GATE_IDLE: begin
          if (cmdBegin) begin
            count_next = '0;
            // Gating off means the acquisition start is made here at once.
            state_next = gatingOn ? GATE_WAIT_ACQ       // see R03
                                  : GATE_WAIT_FRAME;    // see R13
          end
        end
        GATE_WAIT_ACQ: begin
          if (!gatingOn) begin
            state_next = GATE_WAIT_FRAME;               // see R13
            count_next = '0;
          end else if (acqTrig) begin
            state_next = GATE_WAIT_FRAME;               // see R05, R07
            count_next = '0;                            // see R16
          end
        end
        GATE_WAIT_FRAME: begin
          if (frameTaken) begin
            if (lastFrame) begin
              state_next = GATE_WAIT_ACQ;               // see R06
              count_next = '0;
            end else begin
              count_next = count_reg + 8'h01;           // see R16
            end
          end
        end
        default: begin
          state_next = GATE_IDLE;
          count_next = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave registers. The slave never stalls and always answers OKAY.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPending_reg <= 1'b0;
      wrAddr_reg    <= '0;
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b0;
    end else begin
      wrPending_reg <= addrPhase & hwrite;
      wrAddr_reg    <= haddr;
      hreadyout_reg <= 1'b1;
      if (addrPhase && !hwrite) begin
        hrdata_reg <= readData;
      end
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg   <= CTRL_RESET;
      frames_reg <= FRAMES_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl_reg <= hwdata[CTRL_WIDTH-1:0];
      end
      if (wrFrames && framesValid) begin
        frames_reg <= hwdata[COUNT_WIDTH-1:0];          // see R01
      end
    end
  end

  // Gate state, counter and registered outputs.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg      <= GATE_IDLE;
      count_reg      <= '0;
      frameBegin_reg <= 1'b0;
      waitAcq_reg    <= 1'b0;
      waitFrame_reg  <= 1'b0;
    end else begin
      state_reg      <= state_next;
      count_reg      <= count_next;
      frameBegin_reg <= frameTaken & ~cmdEnd;           // see R15
      waitAcq_reg    <= (state_next == GATE_WAIT_ACQ);
      waitFrame_reg  <= (state_next == GATE_WAIT_FRAME);
    end
  end

  assign hrdata            = hrdata_reg;
  assign hreadyout         = hreadyout_reg;
  assign hresp             = HRESP_OKAY;
  assign frameBegin        = frameBegin_reg;
  assign waitingAcqStart   = waitAcq_reg;
  assign waitingFrameStart = waitFrame_reg;

endmodule // acq_start_gate

// ==== acq_gate_monitor.sv ====
/*
  Port checker for the acquisition start gate.
  Assumes it is bound to acq_start_gate and that rst is active high.
*/
module acq_gate_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic frameStartIn,
  input wire logic frameBegin,
  input wire logic waitingAcqStart,
  input wire logic waitingFrameStart
);
  timeunit 1ns;
  timeprecision 1ps;

  // One clock domain, so clock and reset are given once here.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////
  // A frame start arriving while the gate is open, or while it is shut.
  sequence s_take;
    waitingFrameStart && frameStartIn;
  endsequence
  sequence s_shut;
    !waitingFrameStart && frameStartIn;
  endsequence

  a_frame_taken: assert property (s_take |=> frameBegin)
    else $error("Open gate did not begin a frame.");
  a_frame_blocked: assert property (s_shut |=> !frameBegin)
    else $error("Shut gate began a frame.");
  a_begin_cause: assert property (frameBegin |->
    $past(waitingFrameStart) && $past(frameStartIn))
    else $error("Frame began without an accepted frame start.");
  a_pulse_once: assert property (frameBegin && !frameStartIn
    |=> !frameBegin)
    else $error("Frame begin pulse lasted too long.");
  a_one_state: assert property (
    !(waitingAcqStart && waitingFrameStart))
    else $error("Both waiting states shown at once.");
  a_close_last: assert property ($rose(waitingAcqStart) &&
    $past(waitingFrameStart) |-> frameBegin)
    else $error("Gate closed without the last frame.");
  a_ready_up: assert property (!$past(rst) |-> hreadyout)
    else $error("Bus slave inserted a wait state.");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("Bus slave gave a response other than okay.");
endmodule // acq_gate_monitor

bind acq_start_gate acq_gate_monitor mon_u (
  .ref_clk          (ref_clk),
  .rst              (rst),
  .hreadyout        (hreadyout),
  .hresp            (hresp),
  .frameStartIn     (frameStartIn),
  .frameBegin       (frameBegin),
  .waitingAcqStart  (waitingAcqStart),
  .waitingFrameStart(waitingFrameStart)
);

// ==== trig_source_model.sv ====
/*
  External trigger source on input line 1.
  Assumes the receiver synchronises the line; each level is held long
  enough to pass two flops and the edge compare.
*/
module trig_source_model (
  input  wire logic ref_clk,
  output logic      lineIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line idles low; a driven source never floats.
  initial lineIn = 1'b0;

  // New level just after an edge, then held for six cycles.
  task automatic drive(input logic lvl);
    @(posedge ref_clk);
    lineIn <= lvl;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule // trig_source_model

// ==== acq_start_gate_tb.sv ====
/*
  Self-checking bench for the acquisition start gate.
  Assumes the register map and state codes of acq_gate_pkg.
*/
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module acq_start_gate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acq_gate_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        frameStartIn = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  wire logic   lineIn, hreadyout, hresp, frameBegin;
  wire logic   waitingAcqStart, waitingFrameStart;
  wire logic [31:0] hrdata;
  int          failures = 0;
  int          n_tests = 0;

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  acq_start_gate dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .lineIn(lineIn),
    .frameStartIn(frameStartIn), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .frameBegin(frameBegin),
    .waitingAcqStart(waitingAcqStart),
    .waitingFrameStart(waitingFrameStart));
  trig_source_model trig_u (.ref_clk(ref_clk), .lineIn(lineIn));

  //////////////////////////////////////////////////////////////////////////
  // One AHB-Lite single transfer; waits are cut short by the watchdog.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  // One frame start pulse; frameBegin is looked at in the cycle after.
  task automatic fs(input logic e);
    frameStartIn <= 1'b1;
    @(posedge ref_clk);
    frameStartIn <= 1'b0;
    #1 `CHK("frameBegin", e, frameBegin)
    @(posedge ref_clk);
  endtask
  // Gate state at the pins and in the status register, plus the count.
  task automatic st(input logic [1:0] e, input logic [7:0] c);
    logic [31:0] r;
    repeat (2) @(posedge ref_clk);
    bus(1'b0, STATUS_OFFSET, 32'h0, r);
    `CHK("pins", e, {waitingFrameStart, waitingAcqStart})
    `CHK("state", e, r[1:0])
    `CHK("count", c, r[15:8])
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped read, count range limits.
  task automatic t_regs;
    logic [31:0] r;
    bus(1'b0, CTRL_OFFSET, 32'h0, r);
    `CHK("ctrl", 32'(CTRL_RESET), r)
    bus(1'b0, 8'h20, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    wr(FRAMES_OFFSET, 32'h0);
    wr(FRAMES_OFFSET, 32'h100);
    bus(1'b0, FRAMES_OFFSET, 32'h0, r);
    `CHK("frames", 32'h1, r)
    wr(FRAMES_OFFSET, 32'hFF);
    bus(1'b0, FRAMES_OFFSET, 32'h0, r);
    `CHK("frames", 32'hFF, r)
  endtask
  // Software trigger, wrong target, count of two, reopen and stop.
  task automatic t_soft;
    wr(CTRL_OFFSET, 32'h13);
    wr(FRAMES_OFFSET, 32'h2);
    wr(CMD_OFFSET, 32'h1);
    st(GATE_WAIT_ACQ, 8'h0);
    fs(1'b0);
    wr(CTRL_OFFSET, 32'h11);
    wr(CMD_OFFSET, 32'h4);
    st(GATE_WAIT_ACQ, 8'h0);
    wr(CTRL_OFFSET, 32'h13);
    wr(CMD_OFFSET, 32'h4);
    st(GATE_WAIT_FRAME, 8'h0);
    fs(1'b1);
    st(GATE_WAIT_FRAME, 8'h1);
    fs(1'b1);
    st(GATE_WAIT_ACQ, 8'h0);
    wr(CMD_OFFSET, 32'h4);
    st(GATE_WAIT_FRAME, 8'h0);
    wr(CMD_OFFSET, 32'h2);
    st(GATE_IDLE, 8'h0);
  endtask
  // Line trigger on each polarity; the rising edge is shown to do nothing while falling is selected.
  task automatic t_line;
    wr(CTRL_OFFSET, 32'h1F);
    wr(FRAMES_OFFSET, 32'h1);
    wr(CMD_OFFSET, 32'h1);
    trig_u.drive(1'b1);
    st(GATE_WAIT_ACQ, 8'h0);
    trig_u.drive(1'b0);
    st(GATE_WAIT_FRAME, 8'h0);
    fs(1'b1);
    st(GATE_WAIT_ACQ, 8'h0);
    wr(CTRL_OFFSET, 32'h17);
    trig_u.drive(1'b1);
    st(GATE_WAIT_FRAME, 8'h0);
    wr(CMD_OFFSET, 32'h2);
    trig_u.drive(1'b0);
  endtask
  // Gating off opens at once and never closes on its own.
  task automatic t_off;
    wr(CTRL_OFFSET, 32'h10);
    wr(CMD_OFFSET, 32'h1);
    st(GATE_WAIT_FRAME, 8'h0);
    repeat (3) fs(1'b1);
    st(GATE_WAIT_FRAME, 8'h3);
    wr(CMD_OFFSET, 32'h2);
    st(GATE_IDLE, 8'h0);
    fs(1'b0);
  endtask
  // Gating dropped while waiting, unused writes and reads, mid-run reset.
  task automatic t_misc;
    logic [31:0] r;
    wr(CTRL_OFFSET, 32'h13);
    wr(CMD_OFFSET, 32'h1);
    st(GATE_WAIT_ACQ, 8'h0);
    wr(CTRL_OFFSET, 32'h10);
    st(GATE_WAIT_FRAME, 8'h0);
    wr(8'h20, 32'h1F);
    bus(1'b0, CTRL_OFFSET, 32'h0, r);
    `CHK("ctrl kept", 32'h10, r)
    bus(1'b0, CMD_OFFSET, 32'h0, r);
    `CHK("cmd read", 32'h0, r)
    wr(CMD_OFFSET, 32'h2);
    st(GATE_IDLE, 8'h0);
    wr(CTRL_OFFSET, 32'h13);
    wr(FRAMES_OFFSET, 32'h5);
    wr(CMD_OFFSET, 32'h1);
    // A second reset in mid-acquisition must bring back idle and defaults.
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    st(GATE_IDLE, 8'h0);
    bus(1'b0, FRAMES_OFFSET, 32'h0, r);
    `CHK("frames reset", 32'(FRAMES_RESET), r)
    bus(1'b0, CTRL_OFFSET, 32'h0, r);
    `CHK("ctrl reset", 32'(CTRL_RESET), r)
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, shared with the watchdog.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // The scenarios take about two hundred cycles; 100 us is ample.
  initial begin
    #100us;
    failures++;
    tally_and_finish;
  end
  // Reset for eight cycles, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_regs;
    t_soft;
    t_line;
    t_off;
    t_misc;
    tally_and_finish;
  end
endmodule // acq_start_gate_tb
